// >>> rtl/dioc_top.sv
// digital i/o channel supervisor: input conditioning, output fallback, fault and count checks
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// R1 - input supply short raises a unit error if checked
// R2 - input open wire raises a channel error if checked
// R3 - inrush option ignores excess current for 100 ms after inrush
// R4 - input changes shorter than the filter time are ignored
// R5 - a detected input is held for the extension time
// R6 - input ON count above limit x 1000 raises a channel error if enabled
// R7 - counts are saved hourly and restored by writing them back
// R8 - load short raises a unit error if checked
// R9 - auto restart clears a fixed short error; manual holds until reset
// R10 - output open wire raises a channel error if checked
// R11 - on comm fault each output goes off, holds or forces on
// R12 - on comm idle each output goes off, holds or forces on
// R13 - fault and idle settings apply only with handheld hold/clear priority
// R14 - output ON count above limit x 1000 raises a channel error if enabled
// R15 - an ON count increments on each filtered off-to-on transition
// R16 - fault and idle arrive as separate fieldbus indications
module dioc_top
#(
   parameter int N_IN = 8,
   parameter int N_OUT = 8,
   parameter int SAVE_TICKS = dioc_pkg::SAVE_TICKS
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [N_IN-1:0] in_raw_i,
   input wire logic [N_IN-1:0] in_open_i,
   input wire logic supply_short_i,
   input wire logic [N_OUT-1:0] out_open_i,
   input wire logic load_short_i,
   input wire logic comm_fault_i,
   input wire logic comm_idle_i,
   output logic [N_OUT-1:0] out_o,
   output logic nv_save_o,
   output logic irq_o
);
   initial
   begin
      if (N_IN < 1 || N_IN > 16 || N_OUT < 1 || N_OUT > 16 || SAVE_TICKS < 1)
         $error("dioc_top: bad parameter");
   end

   // ----------------------------------------
   // time base and channel conditioners
   // ----------------------------------------
   localparam int TCW = $clog2(dioc_pkg::TICK_CYC);
   localparam logic [TCW-1:0] TICK_LAST = TCW'(dioc_pkg::TICK_CYC - 1);
   localparam logic [31:0] SAVE_LAST = 32'(SAVE_TICKS - 1);
   localparam logic [dioc_pkg::TW-1:0] INRUSH_T = dioc_pkg::TW'(dioc_pkg::INRUSH_TICKS);

   dioc_cond_if cond ();
   logic [TCW-1:0] div_q, div_d;
   logic tick_q, tick_d;
   logic [12:0] ctrl_q, ctrl_d;
   logic [N_IN-1:0] in_lvl, in_rise;

   function automatic logic [dioc_pkg::TW-1:0] us2t(input int us);
      return dioc_pkg::TW'(us / dioc_pkg::TICK_US);
   endfunction

   assign cond.tick = tick_q;
   always_comb
   begin
      case (ctrl_q[dioc_pkg::C_FILT +: 2]) // R4
         2'h0: cond.filt_ticks = us2t(dioc_pkg::FILT_US_0);
         2'h1: cond.filt_ticks = us2t(dioc_pkg::FILT_US_1);
         2'h2: cond.filt_ticks = us2t(dioc_pkg::FILT_US_2);
         default: cond.filt_ticks = us2t(dioc_pkg::FILT_US_3);
      endcase
      case (ctrl_q[dioc_pkg::C_EXT +: 2]) // R5
         2'h0: cond.ext_ticks = us2t(dioc_pkg::EXT_US_0);
         2'h1: cond.ext_ticks = us2t(dioc_pkg::EXT_US_1);
         2'h2: cond.ext_ticks = us2t(dioc_pkg::EXT_US_2);
         default: cond.ext_ticks = us2t(dioc_pkg::EXT_US_3);
      endcase
   end

   generate
      for (genvar g = 0; g < N_IN; g++)
      begin : g_in
         dioc_in_chan u_chan
         (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg(cond.chan),
            .raw_i(in_raw_i[g]),
            .level_o(in_lvl[g]),
            .rise_o(in_rise[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   logic [2*N_OUT-1:0] fmode_q, fmode_d, imode_q, imode_d;
   logic [N_OUT-1:0] odata_q, odata_d, out_q, out_d;
   logic [15:0] ilim_q, ilim_d, olim_q, olim_d;
   logic [31:0] icnt_q [N_IN], icnt_d [N_IN];
   logic [31:0] ocnt_q [N_OUT], ocnt_d [N_OUT];
   logic [dioc_pkg::TW-1:0] blank_q, blank_d;
   logic sup_err_q, sup_err_d, load_err_q, load_err_d;
   logic [N_IN-1:0] iopen_q, iopen_d, icerr_q, icerr_d;
   logic [N_OUT-1:0] oopen_q, oopen_d, ocerr_q, ocerr_d;
   logic [dioc_pkg::NIRQ-1:0] ist_q, ist_d, imask_q, imask_d, ev;
   logic ack_q, ack_d, irq_q, irq_d, save_ev_q, save_ev_d;
   logic wr;
   logic [31:0] ilim_k, olim_k, wsel, save_q, save_d, rdat_q, rdat_d;

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
   assign wsel = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign ilim_k = 32'(ilim_q) * 32'(dioc_pkg::CNT_SCALE); // R6
   assign olim_k = 32'(olim_q) * 32'(dioc_pkg::CNT_SCALE); // R14

   function automatic logic [31:0] merge(input logic [31:0] old, nw, m);
      return (old & ~m) | (nw & m);
   endfunction

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb
   begin
      logic [31:0] t;
      logic [1:0] m;
      logic blanked, sc_sup, sc_load, hh;
      t = '0;
      m = '0;
      hh = ctrl_q[dioc_pkg::C_HANDHELD];
      blanked = ctrl_q[dioc_pkg::C_INRUSH] && blank_q != '0; // R3
      sc_sup = supply_short_i & ~blanked;
      sc_load = load_short_i & ~blanked;
      div_d = (div_q == TICK_LAST) ? '0 : div_q + 1'b1;
      tick_d = (div_q == TICK_LAST);
      ctrl_d = ctrl_q;
      fmode_d = fmode_q;
      imode_d = imode_q;
      odata_d = odata_q;
      ilim_d = ilim_q;
      olim_d = olim_q;
      imask_d = imask_q;
      sup_err_d = ctrl_q[dioc_pkg::C_SUP_SHORT] & sc_sup; // R1
      if (!ctrl_q[dioc_pkg::C_LOAD_SHORT])
         load_err_d = 1'b0;
      else if (ctrl_q[dioc_pkg::C_RESTART])
         load_err_d = load_err_q | sc_load; // R9
      else
         load_err_d = sc_load; // R8 R9
      iopen_d = ctrl_q[dioc_pkg::C_IN_OPEN] ? in_open_i : '0; // R2
      oopen_d = ctrl_q[dioc_pkg::C_OUT_OPEN] ? out_open_i : '0; // R10
      save_ev_d = 1'b0;
      save_d = save_q;
      if (tick_q)
      begin
         save_d = (save_q == SAVE_LAST) ? '0 : save_q + 1'b1;
         save_ev_d = (save_q == SAVE_LAST); // R7
      end
      // output fallback
      for (int i = 0; i < N_OUT; i++)
      begin
         if (comm_fault_i) // R16
            m = hh ? fmode_q[2*i +: 2] : dioc_pkg::MODE_CLEAR; // R11 R13
         else if (comm_idle_i)
            m = hh ? imode_q[2*i +: 2] : dioc_pkg::MODE_CLEAR; // R12 R13
         else
            m = odata_q[i] ? dioc_pkg::MODE_FORCE_ON : dioc_pkg::MODE_CLEAR;
         if (m == dioc_pkg::MODE_HOLD)
            out_d[i] = out_q[i];
         else
            out_d[i] = (m == dioc_pkg::MODE_FORCE_ON);
      end
      // inrush window restarts whenever an output switches on
      blank_d = blank_q;
      if ((out_d & ~out_q) != '0)
         blank_d = INRUSH_T; // R3
      else if (tick_q && blank_q != '0)
         blank_d = blank_q - 1'b1;
      // on counters; a software write restores a saved value
      for (int i = 0; i < N_IN; i++)
      begin
         icnt_d[i] = icnt_q[i] + 32'(in_rise[i]); // R15
         if (wr && wb_adr_i == dioc_pkg::A_IN_CNT + 8'(4 * i))
            icnt_d[i] = merge(icnt_q[i], wb_dat_i, wsel); // R7
         icerr_d[i] = ctrl_q[dioc_pkg::C_IN_CNT] && icnt_q[i] > ilim_k; // R6
      end
      for (int i = 0; i < N_OUT; i++)
      begin
         ocnt_d[i] = ocnt_q[i] + 32'(out_d[i] & ~out_q[i]); // R14
         if (wr && wb_adr_i == dioc_pkg::A_OUT_CNT + 8'(4 * i))
            ocnt_d[i] = merge(ocnt_q[i], wb_dat_i, wsel); // R7
         ocerr_d[i] = ctrl_q[dioc_pkg::C_OUT_CNT] && ocnt_q[i] > olim_k; // R14
      end
      // error onsets and the save event feed the sticky status
      ev = '0;
      ev[dioc_pkg::I_SUP_SHORT] = sup_err_d & ~sup_err_q;
      ev[dioc_pkg::I_LOAD_SHORT] = load_err_d & ~load_err_q;
      ev[dioc_pkg::I_IN_OPEN] = |(iopen_d & ~iopen_q);
      ev[dioc_pkg::I_OUT_OPEN] = |(oopen_d & ~oopen_q);
      ev[dioc_pkg::I_IN_CNT] = |(icerr_d & ~icerr_q);
      ev[dioc_pkg::I_OUT_CNT] = |(ocerr_d & ~ocerr_q);
      ev[dioc_pkg::I_SAVE] = save_ev_d;
      ist_d = ist_q;
      // register writes
      if (wr)
      begin
         if (wb_adr_i == dioc_pkg::A_CTRL)
            ctrl_d = 13'(merge(32'(ctrl_q), wb_dat_i, wsel));
         else if (wb_adr_i == dioc_pkg::A_FAULT_MODE)
            fmode_d = (2*N_OUT)'(merge(32'(fmode_q), wb_dat_i, wsel));
         else if (wb_adr_i == dioc_pkg::A_IDLE_MODE)
            imode_d = (2*N_OUT)'(merge(32'(imode_q), wb_dat_i, wsel));
         else if (wb_adr_i == dioc_pkg::A_OUT_DATA)
            odata_d = N_OUT'(merge(32'(odata_q), wb_dat_i, wsel));
         else if (wb_adr_i == dioc_pkg::A_IN_LIMIT)
            ilim_d = 16'(merge(32'(ilim_q), wb_dat_i, wsel));
         else if (wb_adr_i == dioc_pkg::A_OUT_LIMIT)
            olim_d = 16'(merge(32'(olim_q), wb_dat_i, wsel));
         else if (wb_adr_i == dioc_pkg::A_IRQ_STAT)
            ist_d = ist_q & ~dioc_pkg::NIRQ'(wb_dat_i & wsel);
         else if (wb_adr_i == dioc_pkg::A_IRQ_MASK)
            imask_d = dioc_pkg::NIRQ'(merge(32'(imask_q), wb_dat_i, wsel));
      end
      // a new event outranks a clear in the same cycle
      ist_d = ist_d | ev;
      irq_d = |(ist_d & imask_d);
      // register reads; unmapped addresses return zero
      if (wb_adr_i == dioc_pkg::A_CTRL)
         t = 32'(ctrl_q);
      else if (wb_adr_i == dioc_pkg::A_FAULT_MODE)
         t = 32'(fmode_q);
      else if (wb_adr_i == dioc_pkg::A_IDLE_MODE)
         t = 32'(imode_q);
      else if (wb_adr_i == dioc_pkg::A_OUT_DATA)
         t = 32'(odata_q);
      else if (wb_adr_i == dioc_pkg::A_IN_LIMIT)
         t = 32'(ilim_q);
      else if (wb_adr_i == dioc_pkg::A_OUT_LIMIT)
         t = 32'(olim_q);
      else if (wb_adr_i == dioc_pkg::A_STATE)
         t = {8'h00, 8'(out_q), 16'(in_lvl)};
      else if (wb_adr_i == dioc_pkg::A_UNIT_ERR)
         t = {30'h0, load_err_q, sup_err_q};
      else if (wb_adr_i == dioc_pkg::A_IN_OPEN_ERR)
         t = 32'(iopen_q);
      else if (wb_adr_i == dioc_pkg::A_OUT_OPEN_ERR)
         t = 32'(oopen_q);
      else if (wb_adr_i == dioc_pkg::A_IN_CNT_ERR)
         t = 32'(icerr_q);
      else if (wb_adr_i == dioc_pkg::A_OUT_CNT_ERR)
         t = 32'(ocerr_q);
      else if (wb_adr_i == dioc_pkg::A_IRQ_STAT)
         t = 32'(ist_q);
      else if (wb_adr_i == dioc_pkg::A_IRQ_MASK)
         t = 32'(imask_q);
      for (int i = 0; i < N_IN; i++)
         if (wb_adr_i == dioc_pkg::A_IN_CNT + 8'(4 * i))
            t = icnt_q[i];
      for (int i = 0; i < N_OUT; i++)
         if (wb_adr_i == dioc_pkg::A_OUT_CNT + 8'(4 * i))
            t = ocnt_q[i];
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      rdat_d = ack_d ? t : '0;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_q <= '0;
         tick_q <= 1'b0;
         ctrl_q <= dioc_pkg::CTRL_RST;
         fmode_q <= '0;
         imode_q <= '0;
         odata_q <= '0;
         out_q <= '0;
         ilim_q <= dioc_pkg::LIMIT_RST;
         olim_q <= dioc_pkg::LIMIT_RST;
         for (int i = 0; i < N_IN; i++)
            icnt_q[i] <= '0;
         for (int i = 0; i < N_OUT; i++)
            ocnt_q[i] <= '0;
         blank_q <= INRUSH_T; // R3
         save_q <= '0;
         save_ev_q <= 1'b0;
         sup_err_q <= 1'b0;
         load_err_q <= 1'b0;
         iopen_q <= '0;
         oopen_q <= '0;
         icerr_q <= '0;
         ocerr_q <= '0;
         ist_q <= '0;
         imask_q <= '0;
         rdat_q <= '0;
         ack_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         tick_q <= tick_d;
         ctrl_q <= ctrl_d;
         fmode_q <= fmode_d;
         imode_q <= imode_d;
         odata_q <= odata_d;
         out_q <= out_d;
         ilim_q <= ilim_d;
         olim_q <= olim_d;
         icnt_q <= icnt_d;
         ocnt_q <= ocnt_d;
         blank_q <= blank_d;
         save_q <= save_d;
         save_ev_q <= save_ev_d;
         sup_err_q <= sup_err_d;
         load_err_q <= load_err_d;
         iopen_q <= iopen_d;
         oopen_q <= oopen_d;
         icerr_q <= icerr_d;
         ocerr_q <= ocerr_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         rdat_q <= rdat_d;
         ack_q <= ack_d;
         irq_q <= irq_d;
      end
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   assign out_o = out_q;
   assign nv_save_o = save_ev_q;
   assign irq_o = irq_q;
endmodule

// >>> rtl/dioc_pkg.sv
// constants shared by the digital i/o channel supervisor
package dioc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int FILT_US_0 = 100;
   localparam int FILT_US_1 = 1_000;
   localparam int FILT_US_2 = 10_000;
   localparam int FILT_US_3 = 20_000;
   localparam int EXT_US_0 = 1_000;
   localparam int EXT_US_1 = 15_000;
   localparam int EXT_US_2 = 100_000;
   localparam int EXT_US_3 = 200_000;
   localparam int INRUSH_US = 100_000;
   localparam int INRUSH_TICKS = INRUSH_US / TICK_US;
   localparam int SAVE_S = 3_600;
   localparam int SAVE_TICKS = SAVE_S * (1_000_000 / TICK_US);
   localparam int TW = 11;
   localparam int CNT_SCALE = 1_000;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FAULT_MODE = 8'h08;
   localparam logic [7:0] A_IDLE_MODE = 8'h0c;
   localparam logic [7:0] A_OUT_DATA = 8'h10;
   localparam logic [7:0] A_IN_LIMIT = 8'h14;
   localparam logic [7:0] A_OUT_LIMIT = 8'h18;
   localparam logic [7:0] A_STATE = 8'h1c;
   localparam logic [7:0] A_UNIT_ERR = 8'h20;
   localparam logic [7:0] A_IN_OPEN_ERR = 8'h24;
   localparam logic [7:0] A_OUT_OPEN_ERR = 8'h28;
   localparam logic [7:0] A_IN_CNT_ERR = 8'h2c;
   localparam logic [7:0] A_OUT_CNT_ERR = 8'h30;
   localparam logic [7:0] A_IRQ_STAT = 8'h34;
   localparam logic [7:0] A_IRQ_MASK = 8'h38;
   localparam logic [7:0] A_IN_CNT = 8'h40;
   localparam logic [7:0] A_OUT_CNT = 8'h80;
   // ----------------------------------------
   // control fields and reset values
   // ----------------------------------------
   localparam int C_SUP_SHORT = 0;
   localparam int C_INRUSH = 1;
   localparam int C_FILT = 2;
   localparam int C_EXT = 4;
   localparam int C_LOAD_SHORT = 6;
   localparam int C_RESTART = 7;
   localparam int C_IN_CNT = 8;
   localparam int C_OUT_CNT = 9;
   localparam int C_HANDHELD = 10;
   localparam int C_IN_OPEN = 11;
   localparam int C_OUT_OPEN = 12;
   localparam logic [12:0] CTRL_RST = 13'h0055;
   localparam logic [15:0] LIMIT_RST = 16'hfde8;
   localparam logic [1:0] MODE_CLEAR = 2'h0;
   localparam logic [1:0] MODE_HOLD = 2'h1;
   localparam logic [1:0] MODE_FORCE_ON = 2'h2;
   // interrupt status bits
   localparam int I_SUP_SHORT = 0;
   localparam int I_LOAD_SHORT = 1;
   localparam int I_IN_OPEN = 2;
   localparam int I_OUT_OPEN = 3;
   localparam int I_IN_CNT = 4;
   localparam int I_OUT_CNT = 5;
   localparam int I_SAVE = 6;
   localparam int NIRQ = 7;
endpackage

// >>> rtl/dioc_cond_if.sv
// shared timing carrier from the supervisor to its input channel conditioners
`timescale 1ns/1ps
interface dioc_cond_if;
   logic tick;
   logic [dioc_pkg::TW-1:0] filt_ticks;
   logic [dioc_pkg::TW-1:0] ext_ticks;
   modport ctrl (output tick, output filt_ticks, output ext_ticks);
   modport chan (input tick, input filt_ticks, input ext_ticks);
endinterface

// >>> rtl/dioc_in_chan.sv
// one input channel: change filter, then pulse extension
`timescale 1ns/1ps
module dioc_in_chan
(
   input wire logic clk_i,
   input wire logic rst_i,
   dioc_cond_if.chan cfg,
   input wire logic raw_i,
   output logic level_o,
   output logic rise_o
);
   logic stable_q, stable_d;
   logic [dioc_pkg::TW-1:0] fcnt_q, fcnt_d;
   logic [dioc_pkg::TW-1:0] ecnt_q, ecnt_d;
   logic level_q, level_d;
   logic rise_q, rise_d;

   // filter resolution is one tick, so a change is accepted after filt-1 to filt ticks
   always_comb
   begin
      stable_d = stable_q;
      fcnt_d = fcnt_q;
      ecnt_d = ecnt_q;
      if (raw_i == stable_q)
         fcnt_d = '0;
      else if (cfg.tick)
      begin
         if (fcnt_q + 1'b1 >= cfg.filt_ticks) // R4
         begin
            stable_d = raw_i;
            fcnt_d = '0;
         end
         else
            fcnt_d = fcnt_q + 1'b1;
      end
      if (stable_d)
         ecnt_d = cfg.ext_ticks; // R5
      else if (cfg.tick && ecnt_q != '0)
         ecnt_d = ecnt_q - 1'b1;
      level_d = stable_d | (ecnt_d != '0); // R5
      rise_d = stable_d & ~stable_q; // R15
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stable_q <= 1'b0;
         fcnt_q <= '0;
         ecnt_q <= '0;
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end
      else
      begin
         stable_q <= stable_d;
         fcnt_q <= fcnt_d;
         ecnt_q <= ecnt_d;
         level_q <= level_d;
         rise_q <= rise_d;
      end
   end

   assign level_o = level_q;
   assign rise_o = rise_q;
endmodule

// >>> verification/dioc_field_model.sv
// field side model: input sensors and output loads
`timescale 1ns/1ps
module dioc_field_model
(
   input wire logic [7:0] sense_i,
   input wire logic [7:0] in_open_cmd_i,
   input wire logic supply_cmd_i,
   input wire logic [7:0] out_open_cmd_i,
   input wire logic load_cmd_i,
   input wire logic [7:0] out_i,
   output logic [7:0] in_raw_o,
   output logic [7:0] in_open_o,
   output logic supply_short_o,
   output logic [7:0] out_open_o,
   output logic load_short_o
);
   assign in_raw_o = sense_i;
   assign in_open_o = in_open_cmd_i;
   assign supply_short_o = supply_cmd_i;
   assign out_open_o = out_open_cmd_i;
   // a shorted load only draws excess current while it is driven
   assign load_short_o = load_cmd_i & (|out_i);
endmodule

// >>> verification/dioc_top_checker.sv
// port assertions for the supervisor
`timescale 1ns/1ps
module dioc_top_checker
#(
   parameter int N_IN = 8,
   parameter int N_OUT = 8,
   parameter int SAVE_TICKS = 5
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic comm_fault_i,
   input wire logic comm_idle_i,
   input wire logic [N_OUT-1:0] out_o,
   input wire logic nv_save_o,
   input wire logic irq_o
);
   // ----------------------------------------
   // save spacing helper
   // ----------------------------------------
   logic [31:0] gap_q, gap_d;
   logic seen_q, seen_d;
   always_comb
   begin
      gap_d = nv_save_o ? 32'h1 : gap_q + 32'h1;
      seen_d = seen_q | nv_save_o;
   end
   always_ff @(posedge clk_i)
   begin
      gap_q <= rst_i ? 32'h0 : gap_d;
      seen_q <= rst_i ? 1'b0 : seen_d;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_ack_resp;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_zero;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
   property p_reset;
      disable iff (1'b0) rst_i |=> out_o == '0 && !wb_ack_o && !irq_o && !nv_save_o;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not reset");
   property p_out_cause;
      $changed(out_o) |-> $past(wb_ack_o) || $past(comm_fault_i)
         || $past(comm_idle_i) || $past(comm_fault_i, 2) || $past(comm_idle_i, 2);
   endproperty
   a_out_cause: assert property (p_out_cause) else $error("output moved without cause");
   property p_save_pulse;
      nv_save_o |=> !nv_save_o [*8];
   endproperty
   a_save_pulse: assert property (p_save_pulse) else $error("save pulse too long");
   property p_save_gap;
      nv_save_o && seen_q |-> gap_q == SAVE_TICKS * dioc_pkg::TICK_CYC;
   endproperty
   a_save_gap: assert property (p_save_gap) else $error("save period wrong");
endmodule
bind dioc_top dioc_top_checker #(.N_IN(N_IN), .N_OUT(N_OUT), .SAVE_TICKS(SAVE_TICKS)) chk_i (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .comm_fault_i(comm_fault_i), .comm_idle_i(comm_idle_i), .out_o(out_o), .nv_save_o(nv_save_o), .irq_o(irq_o));

// >>> verification/dioc_tb_top.sv
// self-checking bench for the i/o channel supervisor
`timescale 1ns/1ps
module dioc_tb_top;
   localparam int TC = dioc_pkg::TICK_CYC;
   localparam logic [31:0] CR = 32'h0055;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic [7:0] in_raw_i, in_open_i, out_open_i, out_o;
   logic wb_ack_o, supply_short_i, load_short_i, nv_save_o, irq_o;
   logic comm_fault_i = 1'b0, comm_idle_i = 1'b0;
   logic [7:0] sense_q = 8'h00, iopen_q = 8'h00, oopen_q = 8'h00;
   logic sup_q = 1'b0, lsh_q = 1'b0;
   int fails = 0;
   int checks_done = 0;
   always #20 clk_i = ~clk_i;
   dioc_top #(.N_IN(8), .N_OUT(8), .SAVE_TICKS(5)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_raw_i(in_raw_i), .in_open_i(in_open_i),
      .supply_short_i(supply_short_i), .out_open_i(out_open_i), .load_short_i(load_short_i),
      .comm_fault_i(comm_fault_i), .comm_idle_i(comm_idle_i), .out_o(out_o), .nv_save_o(nv_save_o), .irq_o(irq_o));
   dioc_field_model field (.sense_i(sense_q), .in_open_cmd_i(iopen_q), .supply_cmd_i(sup_q),
      .out_open_cmd_i(oopen_q), .load_cmd_i(lsh_q), .out_i(out_o), .in_raw_o(in_raw_i), .in_open_o(in_open_i),
      .supply_short_o(supply_short_i), .out_open_o(out_open_i), .load_short_o(load_short_i));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 100);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 100)
         fails++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, rd & m, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rc("ctrl", dioc_pkg::A_CTRL, '1, CR);
      rc("in limit", dioc_pkg::A_IN_LIMIT, '1, 32'h0000fde8);
      rc("out limit", dioc_pkg::A_OUT_LIMIT, '1, 32'h0000fde8);
      rc("fault mode", dioc_pkg::A_FAULT_MODE, '1, 32'h0);
      rc("mask", dioc_pkg::A_IRQ_MASK, '1, 32'h0);
      wr(8'h3c, 32'hffffffff);
      rc("unmapped", 8'h3c, '1, 32'h0);
   endtask
   task automatic t_out();
      wr(dioc_pkg::A_OUT_LIMIT, 32'h1);
      wr(dioc_pkg::A_OUT_CNT, 32'd1000);
      wr(dioc_pkg::A_CTRL, CR | 32'h200);
      rc("out cnt err at limit", dioc_pkg::A_OUT_CNT_ERR, '1, 32'h0);
      wr(dioc_pkg::A_OUT_DATA, 32'h1);
      cyc(3);
      chk("out", {24'h0, out_o}, 32'h1);
      rc("out cnt", dioc_pkg::A_OUT_CNT, '1, 32'd1001);
      rc("out cnt err", dioc_pkg::A_OUT_CNT_ERR, '1, 32'h1);
   endtask
   task automatic t_fallback();
      wr(dioc_pkg::A_OUT_DATA, 32'h0f);
      @(posedge clk_i);
      comm_fault_i <= 1'b1;
      cyc(3);
      chk("out fault plain", {24'h0, out_o}, 32'h0);
      comm_fault_i <= 1'b0;
      wr(dioc_pkg::A_CTRL, CR | 32'h400);
      wr(dioc_pkg::A_FAULT_MODE, 32'h0224);
      comm_fault_i <= 1'b1;
      cyc(3);
      chk("out fault", {24'h0, out_o}, 32'h16);
      comm_idle_i <= 1'b1;
      cyc(3);
      chk("out fault idle", {24'h0, out_o}, 32'h16);
      comm_fault_i <= 1'b0;
      wr(dioc_pkg::A_IDLE_MODE, 32'haaaa);
      cyc(3);
      chk("out idle", {24'h0, out_o}, 32'hff);
      comm_idle_i <= 1'b0;
      cyc(3);
      chk("out normal", {24'h0, out_o}, 32'h0f);
   endtask
   task automatic t_irq();
      wr(dioc_pkg::A_IRQ_MASK, 32'h2);
      lsh_q <= 1'b1;
      cyc(4);
      rc("unit err", dioc_pkg::A_UNIT_ERR, 32'h2, 32'h2);
      chk("irq", 32'(irq_o), 32'h1);
      lsh_q <= 1'b0;
      cyc(4);
      rc("unit err auto", dioc_pkg::A_UNIT_ERR, 32'h2, 32'h0);
      chk("irq sticky", 32'(irq_o), 32'h1);
      wr(dioc_pkg::A_IRQ_STAT, 32'h2);
      cyc(2);
      chk("irq cleared", 32'(irq_o), 32'h0);
      wr(dioc_pkg::A_CTRL, CR | 32'h80);
      wr(dioc_pkg::A_IRQ_MASK, 32'h0);
      lsh_q <= 1'b1;
      cyc(4);
      lsh_q <= 1'b0;
      cyc(4);
      rc("unit err manual", dioc_pkg::A_UNIT_ERR, 32'h2, 32'h2);
      rc("stat", dioc_pkg::A_IRQ_STAT, 32'h2, 32'h2);
      chk("irq masked", 32'(irq_o), 32'h0);
   endtask
   task automatic t_open();
      iopen_q <= 8'h08;
      oopen_q <= 8'h40;
      sup_q <= 1'b1;
      cyc(4);
      rc("in open off", dioc_pkg::A_IN_OPEN_ERR, '1, 32'h0);
      rc("out open off", dioc_pkg::A_OUT_OPEN_ERR, '1, 32'h0);
      rc("supply err", dioc_pkg::A_UNIT_ERR, 32'h1, 32'h1);
      wr(dioc_pkg::A_CTRL, CR | 32'h1802);
      cyc(4);
      rc("in open", dioc_pkg::A_IN_OPEN_ERR, '1, 32'h08);
      rc("out open", dioc_pkg::A_OUT_OPEN_ERR, '1, 32'h40);
      rc("supply blanked", dioc_pkg::A_UNIT_ERR, 32'h1, 32'h0);
      iopen_q <= 8'h00;
      oopen_q <= 8'h00;
      sup_q <= 1'b0;
   endtask
   task automatic t_input();
      sense_q <= 8'h01;
      cyc(5 * TC);
      sense_q <= 8'h00;
      cyc(2 * TC);
      rc("short pulse", dioc_pkg::A_STATE, 32'hffff, 32'h0);
      rc("in cnt idle", dioc_pkg::A_IN_CNT, '1, 32'h0);
      wr(dioc_pkg::A_IN_LIMIT, 32'h1);
      wr(dioc_pkg::A_IN_CNT, 32'd1000);
      wr(dioc_pkg::A_CTRL, 32'h0141);
      sense_q <= 8'h01;
      cyc(3 * TC);
      rc("level", dioc_pkg::A_STATE, 32'hffff, 32'h1);
      rc("in cnt", dioc_pkg::A_IN_CNT, '1, 32'd1001);
      rc("in cnt err", dioc_pkg::A_IN_CNT_ERR, '1, 32'h1);
      sense_q <= 8'h00;
      cyc(5 * TC);
      rc("stretched", dioc_pkg::A_STATE, 32'hffff, 32'h1);
      cyc(10 * TC);
      rc("released", dioc_pkg::A_STATE, 32'hffff, 32'h0);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_out();
      t_fallback();
      t_irq();
      t_open();
      t_input();
      results();
   end
   // tests take about 63000 cycles
   initial
   begin
      repeat (90000) @(posedge clk_i);
      fails++;
      results();
   end
endmodule
